// [readout_unprotect_keys_tb_top.sv]
`timescale 1ns/1ps
module readout_unprotect_keys_tb_top;
  import rup_pkg::*;
  logic sys_clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
  logic unprotected_out, erase_req_out, boot_force_out;
  logic [7:0] paddr;
  logic [7:0] key [RUP_KEYS];
  logic [31:0] pwdata, prdata, q;
  logic [31:0] seed = 32'h7B569F1F;
  int n_fail = 0;
  int comparisons = 0;
  rup_top i_dut (.sys_clk_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .unprotected_out, .erase_req_out, .boot_force_out);
  rup_host i_host (.clk_in(sys_clk_in), .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // device needs eight cycles to judge a try
  task automatic try_unlock();
    wr(RUP_ADDR_TRY, 32'h1);
    repeat (12) @(posedge sys_clk_in);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #5000;
    n_fail++;
    final_report();
  end
  initial begin
    rst_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(RUP_ADDR_CFG, 32'h5);
    wr(RUP_ADDR_FAIL, 32'h6);
    rd(RUP_ADDR_FAIL, 32'h6);
    wr(RUP_ADDR_CFG, 32'hA);
    wr(RUP_ADDR_FAIL, 32'h1);
    rd(RUP_ADDR_FAIL, 32'h6);
    rd(RUP_ADDR_STAT, 32'h1);
    wr(RUP_ADDR_STAT, 32'h1);
    rd(RUP_ADDR_STAT, 32'h0);
    $display("counter preset test done");
    for (int i = 0; i < RUP_KEYS; i++) begin
      key[i] = 8'(rnd() % 254 + 1);
      wr(RUP_ADDR_KEY0 + 8'(4 * i), {24'h0, key[i]});
      wr(RUP_ADDR_SUPP0 + 8'(4 * i), {24'h0, key[i]});
    end
    chk(32'(unprotected_out), 32'h0);
    try_unlock();
    chk(32'(unprotected_out), 32'h1);
    // first miss only in byte zero, then only in the last byte
    wr(RUP_ADDR_SUPP0, {24'h0, ~key[0]});
    for (int n = 7; n <= 8; n++) begin
      try_unlock();
      rd(RUP_ADDR_FAIL, 32'(n));
      wr(RUP_ADDR_SUPP0, {24'h0, key[0]});
      wr(RUP_ADDR_SUPP0 + 8'h1C, {24'h0, ~key[7]});
    end
    chk(32'(erase_req_out), 32'h1);
    $display("unlock and erase test done");
    wr(RUP_ADDR_BOOT, {24'h0, RUP_BOOT_ON});
    wr(RUP_ADDR_BOOTC, {24'h0, RUP_BOOT_ON_CPL});
    repeat (2) @(posedge sys_clk_in);
    chk(32'(boot_force_out), 32'h1);
    wr(RUP_ADDR_BOOTC, {24'h0, RUP_BOOT_ON});
    repeat (2) @(posedge sys_clk_in);
    chk(32'(boot_force_out), 32'h0);
    i_host.xfer(1'b0, 8'hFC, 32'h0, q);
    chk(32'(i_host.err_q), 32'h1);
    $display("boot and unmapped test done");
    final_report();
  end
endmodule

// [rup_host.sv]
`timescale 1ns/1ps
module rup_host (
  // apb master side
  input wire logic clk_in,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  logic err_q = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// [rup_key_mem.sv]
`timescale 1ns/1ps
module rup_key_mem (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [2:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  // read port
  input wire logic [2:0] rd_idx_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_r [8];
  logic [7:0] rd_r;
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_idx_in] <= wr_data_in;
    end
    if (rst_in) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= mem_r[rd_idx_in];
    end
  end
  assign rd_data_out = rd_r;
endmodule

// [rup_pkg.sv]
package rup_pkg;
  localparam int RUP_KEYS = 8;
  localparam logic [7:0] RUP_KEY_ZERO = 8'h00;
  localparam logic [7:0] RUP_KEY_ONES = 8'hFF;
  localparam logic [3:0] RUP_TMU_DISABLED = 4'h5;
  localparam logic [7:0] RUP_FAIL_LIMIT = 8'h08;
  localparam logic [7:0] RUP_BOOT_ON = 8'h55;
  localparam logic [7:0] RUP_BOOT_ON_CPL = 8'hAA;
  localparam logic [7:0] RUP_ONE = 8'h01;
  localparam logic [7:0] RUP_ZERO8 = 8'h00;
  // register byte addresses
  localparam logic [7:0] RUP_ADDR_KEY0 = 8'h00;
  localparam logic [7:0] RUP_ADDR_FAIL = 8'h20;
  localparam logic [7:0] RUP_ADDR_BOOT = 8'h24;
  localparam logic [7:0] RUP_ADDR_BOOTC = 8'h28;
  localparam logic [7:0] RUP_ADDR_CFG = 8'h2C;
  localparam logic [7:0] RUP_ADDR_TRY = 8'h30;
  localparam logic [7:0] RUP_ADDR_STAT = 8'h34;
  localparam logic [7:0] RUP_ADDR_SUPP0 = 8'h40;
  localparam int RUP_IDX_LSB = 2;
  localparam int RUP_IDX_W = 3;
  typedef struct packed {
    logic unlocked;
    logic erase;
    logic boot;
    logic cfg_err;
  } rup_stat_t;
  typedef enum logic [2:0] {
    RUP_IDLE = 3'b001,
    RUP_CMP = 3'b010,
    RUP_ERASE = 3'b100
  } rup_state_t;
endpackage

// [rup_top.sv]
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - each stored key is one full byte; eight keys at consecutive positions.
// - failure counter writable only when enable field holds disabled code 0101.
// - while enabled, each wrong-key unlock attempt increments the failure counter.
// - counter reaching eight erases code flash and data eeprom.
// - boot byte 0x55 with complement 0xAA forces the bootloader.
module rup_top (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory control
  output logic unprotected_out,
  output logic erase_req_out,
  output logic boot_force_out
);
  import rup_pkg::*;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  function automatic logic is_key(input logic [7:0] a, input logic [7:0] base);
    is_key = (a[7:5] == base[7:5]) && (a[1:0] == 2'b00);
  endfunction

  logic acc;
  logic wr;
  logic key_hit;
  logic supp_hit;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign key_hit = is_key(paddr, RUP_ADDR_KEY0);
  assign supp_hit = is_key(paddr, RUP_ADDR_SUPP0);

  // ----------------------------------------
  // state
  // ----------------------------------------
  rup_state_t st_r, st_nxt;
  logic [7:0] fail_r, fail_nxt;
  logic [7:0] boot_r, boot_nxt;
  logic [7:0] bootc_r, bootc_nxt;
  logic [3:0] cfg_r, cfg_nxt;
  logic [7:0] supp_r [RUP_KEYS];
  logic [2:0] idx_r, idx_nxt;
  logic match_r, match_nxt;
  logic unl_r, unl_nxt;
  logic ers_r, ers_nxt;
  logic bf_r, bf_nxt;
  logic cfgerr_r, cfgerr_nxt;
  logic rdy_r, rdy_nxt;
  logic err_r, err_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [7:0] key_rd;
  rup_stat_t stat;

  // stored keys in their own memory, one byte each
  rup_key_mem u_keys (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_en_in(wr && key_hit && st_r == RUP_IDLE),
    .wr_idx_in(paddr[RUP_IDX_LSB +: RUP_IDX_W]),
    .wr_data_in(pwdata[7:0]),
    .rd_idx_in(idx_nxt),
    .rd_data_out(key_rd)
  );

  // supplied key bytes
  genvar g;
  generate
    for (g = 0; g < RUP_KEYS; g++) begin : g_supp
      always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
          supp_r[g] <= RUP_ZERO8;
        end else if (wr && supp_hit && paddr[RUP_IDX_LSB +: RUP_IDX_W] == 3'(g)) begin
          supp_r[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  assign stat = '{unlocked: unl_r, erase: ers_r, boot: bf_r, cfg_err: cfgerr_r};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    fail_nxt = fail_r;
    boot_nxt = boot_r;
    bootc_nxt = bootc_r;
    cfg_nxt = cfg_r;
    idx_nxt = idx_r;
    match_nxt = match_r;
    unl_nxt = unl_r;
    ers_nxt = ers_r;
    cfgerr_nxt = cfgerr_r;
    rdy_nxt = 1'b0;
    err_nxt = 1'b0;
    rd_nxt = rd_r;
    // bus answers one cycle after setup
    if (psel && !penable) begin
      rdy_nxt = 1'b1;
    end
    if (wr) begin
      if (paddr == RUP_ADDR_FAIL) begin
        if (cfg_r == RUP_TMU_DISABLED) begin
          fail_nxt = pwdata[7:0];
        end else begin
          cfgerr_nxt = 1'b1;
        end
      end
      if (paddr == RUP_ADDR_BOOT) begin
        boot_nxt = pwdata[7:0];
      end
      if (paddr == RUP_ADDR_BOOTC) begin
        bootc_nxt = pwdata[7:0];
      end
      if (paddr == RUP_ADDR_CFG) begin
        cfg_nxt = pwdata[3:0];
      end
      if (paddr == RUP_ADDR_STAT) begin
        cfgerr_nxt = cfgerr_r && !pwdata[0];
        unl_nxt = unl_r && !pwdata[3];
      end
      if (paddr == RUP_ADDR_TRY && st_r == RUP_IDLE && cfg_r != RUP_TMU_DISABLED) begin
        st_nxt = RUP_CMP;
        idx_nxt = 3'd0;
        match_nxt = 1'b1;
      end
    end
    // read data and error are set up during setup so they stand with pready
    if (psel && !penable && !pwrite) begin
      rd_nxt = 32'h0000_0000;
      err_nxt = !(key_hit || supp_hit || paddr == RUP_ADDR_FAIL || paddr == RUP_ADDR_BOOT
                  || paddr == RUP_ADDR_BOOTC || paddr == RUP_ADDR_CFG || paddr == RUP_ADDR_TRY
                  || paddr == RUP_ADDR_STAT);
      if (supp_hit) begin
        rd_nxt[7:0] = supp_r[paddr[RUP_IDX_LSB +: RUP_IDX_W]];
      end
      if (paddr == RUP_ADDR_FAIL) begin
        rd_nxt[7:0] = fail_r;
      end
      if (paddr == RUP_ADDR_BOOT) begin
        rd_nxt[7:0] = boot_r;
      end
      if (paddr == RUP_ADDR_BOOTC) begin
        rd_nxt[7:0] = bootc_r;
      end
      if (paddr == RUP_ADDR_CFG) begin
        rd_nxt[3:0] = cfg_r;
      end
      if (paddr == RUP_ADDR_STAT) begin
        rd_nxt[3:0] = stat;
      end
    end
    case (st_r)
      RUP_IDLE: begin
      end
      RUP_CMP: begin
        // key byte for idx_r arrives one cycle after it is addressed
        if (key_rd != supp_r[idx_r]) begin
          match_nxt = 1'b0;
        end
        if (idx_r == 3'(RUP_KEYS - 1)) begin
          st_nxt = RUP_IDLE;
        end else begin
          idx_nxt = idx_r + 3'd1;
        end
      end
      RUP_ERASE: begin
        ers_nxt = 1'b1;
      end
      default: begin
        st_nxt = RUP_IDLE;
      end
    endcase
    if (st_r == RUP_CMP && idx_r == 3'(RUP_KEYS - 1)) begin
      if (match_nxt && key_rd == supp_r[idx_r]) begin
        unl_nxt = 1'b1;
      end else begin
        fail_nxt = fail_r + RUP_ONE;
        if (fail_r + RUP_ONE >= RUP_FAIL_LIMIT) begin
          st_nxt = RUP_ERASE;
        end
      end
    end
    bf_nxt = (boot_r == RUP_BOOT_ON) && (bootc_r == RUP_BOOT_ON_CPL);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_r <= RUP_IDLE;
      fail_r <= RUP_ZERO8;
      boot_r <= RUP_ZERO8;
      bootc_r <= RUP_ZERO8;
      cfg_r <= RUP_TMU_DISABLED;
      idx_r <= 3'd0;
      match_r <= 1'b0;
      unl_r <= 1'b0;
      ers_r <= 1'b0;
      bf_r <= 1'b0;
      cfgerr_r <= 1'b0;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      rd_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      fail_r <= fail_nxt;
      boot_r <= boot_nxt;
      bootc_r <= bootc_nxt;
      cfg_r <= cfg_nxt;
      idx_r <= idx_nxt;
      match_r <= match_nxt;
      unl_r <= unl_nxt;
      ers_r <= ers_nxt;
      bf_r <= bf_nxt;
      cfgerr_r <= cfgerr_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign pready = rdy_r;
  assign pslverr = err_r;
  assign prdata = rd_r;
  assign unprotected_out = unl_r;
  assign erase_req_out = ers_r;
  assign boot_force_out = bf_r;
endmodule

// [rup_top_sva.sv]
`timescale 1ns/1ps
module rup_top_sva (
  // watched ports
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic unprotected_out,
  input wire logic erase_req_out,
  input wire logic boot_force_out
);
  import rup_pkg::*;
  logic [7:0] since_try_r;
  logic [7:0] since_try_nxt;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // saturates so an old try never looks recent
  always_comb begin
    since_try_nxt = (since_try_r == 8'hFF) ? since_try_r : since_try_r + 8'h01;
    if (psel && penable && pready && pwrite && paddr == RUP_ADDR_TRY) since_try_nxt = 8'h00;
  end
  always_ff @(posedge sys_clk_in) begin
    since_try_r <= rst_in ? 8'hFF : since_try_nxt;
  end
  chk_ready_one_wait: assert property (psel && !penable |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  chk_err_on_read: assert property (pslverr |-> pready && !pwrite) else $error("stray pslverr");
  chk_erase_sticky: assert property (erase_req_out |=> erase_req_out) else $error("erase dropped");
  chk_unlock_after_try: assert property ($rose(unprotected_out) |-> since_try_r <= 8'h0C) else $error("no try");
  chk_boot_by_write: assert property ($changed(boot_force_out) |-> $past(pready && pwrite)
    || $past(pready && pwrite, 2)) else $error("boot moved alone");
  cover property ($rose(unprotected_out));
  cover property ($rose(erase_req_out));
  cover property ($rose(boot_force_out));
endmodule
bind rup_top rup_top_sva i_sva (.sys_clk_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .unprotected_out, .erase_req_out, .boot_force_out);
